/* ecp_pkg.sv */
// constants, types and status layout for the serial eeprom command front end
// assumes nothing of its surroundings; imported by every design file
package ecp_pkg;

    typedef logic [7:0] ecp_byte_t;
    typedef logic [15:0] ecp_addr_t;
    typedef logic [6:0] ecp_pidx_t;

    // instruction codes
    localparam ecp_byte_t OP_SET_LATCH = 8'h06;
    localparam ecp_byte_t OP_CLEAR_LATCH = 8'h04;
    localparam ecp_byte_t OP_STATUS_READ = 8'h05;
    localparam ecp_byte_t OP_STATUS_WRITE = 8'h01;
    localparam ecp_byte_t OP_READ = 8'h03;
    localparam ecp_byte_t OP_WRITE = 8'h02;

    // status register bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_WRITE_LATCH = 1;
    localparam int SR_GUARD_LO = 2;
    localparam int SR_GUARD_HI = 3;
    localparam int SR_PAGE_LOCK = 4;
    localparam int SR_ZERO = 5;
    localparam int SR_PAGE_SELECT = 6;
    localparam int SR_PIN_GUARD = 7;
    localparam ecp_byte_t SR_RESET = 8'h00;

    // block guard encodings and the first guarded address of the quarter and half blocks
    localparam logic [1:0] GUARD_NONE = 2'h0;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_FULL = 2'h3;
    localparam ecp_addr_t GUARD_QUARTER_START = 16'hc000;
    localparam ecp_addr_t GUARD_HALF_START = 16'h8000;

    // identification page and page buffer
    localparam int PAGE_BYTES = 128;
    localparam ecp_byte_t NBYTES_MAX = 8'hff;

    // internal write cycle: longest time, rounded down to cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int WC_TIME_MS = 4;
    localparam int WC_CYCLES = WC_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // frame phases of the serial link
    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR_HI = 3'b001,
        PH_ADDR_LO = 3'b010,
        PH_DATA = 3'b011,
        PH_SKIP = 3'b100
    } ecp_phase_t;

endpackage : ecp_pkg

/* ecp_sync2.sv */
// two flip-flop synchroniser for levels, any width
// assumes each bit is a level that stays put for several destination clocks
`timescale 1ns/1ps
module ecp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import ecp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ecp_sync_t;

    ecp_sync_t r_q;
    ecp_sync_t r_d;

    // no reset: the chain settles within two edges of a running clock
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    assign q = r_q.s2;

endmodule : ecp_sync2

/* ecp_cmd_protect.sv */
// serial eeprom command front end: spi slave, status register, write guard
// assumes a host that frames with cs_n, stops sck while cs_n is high and
// an array engine that reads the page buffer while busy is high
//
// How it works
// R1 - serial input bits are captured on every rising sck edge, modes 0 and 3
// R2 - serial output bits change on every falling sck edge
// R3 - with chip select high the output floats; a running write cycle continues
// R4 - host opens each frame by lowering chip select and closes by raising it
// R5 - host pauses with hold low and resumes high, sck low at both changes
// R6 - first eight bits are the instruction; unknown codes are ignored
// R7 - 03 is memory read, 02 memory write, 01 status write
// R8 - 06 sets the write latch, 04 clears it, 05 reads status
// R9 - status layout: busy, latch, guard pair, lock, zero, page select, pin guard
// R10 - busy is high for the whole write cycle and host writes never touch it
// R11 - set and clear instructions drive the write latch, one means enabled
// R12 - guard field makes none, top quarter, top half or all addresses read only
// R13 - guard pin low with pin guard on refuses status and guarded writes
// R14 - latch low refuses every write; guarded blocks are always refused
// R15 - page select routes reads and writes to the identification page
// R16 - identification page holds 128 bytes apart from the main array
// R17 - page select clears itself once a read or a write completes
// R18 - page lock, once set, keeps the identification page read only forever
// R19 - a status write setting both select and lock changes neither
// R20 - the write cycle ends within 4 ms of the closing chip select edge
// R21 - host waits 1 ms after power is stable before any access
// R22 - during a write cycle only the status read instruction is obeyed
// R23 - page loads advance only the low address bits and wrap in the page
// R24 - a status write changes only bits 2, 3, 4, 6 and 7
// R25 - the write latch clears when a write cycle completes
// R26 - opcode, address and data travel most significant bit first
`timescale 1ns/1ps
module ecp_cmd_protect #(
    parameter int WC_CYCLES_P = ecp_pkg::WC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic wp_n,
    input wire logic hold_n,
    output ecp_pkg::ecp_addr_t read_addr,
    output logic read_id_page,
    input wire ecp_pkg::ecp_byte_t read_data,
    output logic busy,
    output ecp_pkg::ecp_byte_t status,
    output logic prog_start,
    output ecp_pkg::ecp_addr_t prog_addr,
    output ecp_pkg::ecp_byte_t prog_len,
    output logic prog_id_page,
    input wire ecp_pkg::ecp_pidx_t prog_rd_idx,
    output ecp_pkg::ecp_byte_t prog_rd_data
);
    import ecp_pkg::*;

    localparam int TW = $clog2(WC_CYCLES_P + 1);

    generate
        if (WC_CYCLES_P < 1) begin : g_bad_wc
            $error("write cycle count must be at least one");
        end
    endgenerate

    // true when an address falls in the block guarded by the field
    function automatic logic addr_guarded(input ecp_addr_t a, input logic [1:0] g);
        case (g)
            GUARD_NONE: addr_guarded = 1'b0;
            GUARD_QUARTER: addr_guarded = (a >= GUARD_QUARTER_START);
            GUARD_HALF: addr_guarded = (a >= GUARD_HALF_START);
            default: addr_guarded = 1'b1;
        endcase
    endfunction : addr_guarded

    // true for the six instruction codes the device obeys
    function automatic logic op_known(input ecp_byte_t op);
        op_known = (op == OP_SET_LATCH) || (op == OP_CLEAR_LATCH) || (op == OP_STATUS_READ) ||
            (op == OP_STATUS_WRITE) || (op == OP_READ) || (op == OP_WRITE);
    endfunction : op_known

    // frame state on sck rising edges, cleared whenever chip select is high
    typedef struct packed {
        ecp_phase_t ph;
        logic [2:0] bitcnt;
        logic [6:0] sh;
        ecp_byte_t op;
        ecp_byte_t ahi;
        ecp_pidx_t ptr;
        ecp_addr_t raddr;
    } ecp_frame_t;

    // frame summary handed to the system clock; survives chip select high
    typedef struct packed {
        logic tgl;
        ecp_byte_t op;
        logic ok;
        ecp_addr_t addr;
        ecp_byte_t nbytes;
        ecp_byte_t srd;
    } ecp_summary_t;

    // output shifter on sck falling edges
    typedef struct packed {
        ecp_byte_t sh;
        logic so;
        logic oe;
    } ecp_tx_t;

    // system clock side: status register, write timer, engine request
    typedef struct packed {
        logic tgl_seen;
        logic busy;
        logic [TW-1:0] timer;
        logic write_latch_bit;
        logic [1:0] guard;
        logic lock;
        logic sel;
        logic pge;
        logic cyc_mem;
        logic prog_start;
        ecp_addr_t prog_addr;
        ecp_byte_t prog_len;
        logic prog_id;
        ecp_byte_t pb_data;
    } ecp_sys_t;

    ecp_frame_t a_q;
    ecp_frame_t a_d;
    ecp_summary_t b_q;
    ecp_summary_t b_d;
    ecp_tx_t c_q;
    ecp_tx_t c_d;
    ecp_sys_t s_q;
    ecp_sys_t s_d;

    ecp_byte_t pbuf [PAGE_BYTES];
    logic pb_we;
    ecp_pidx_t pb_idx;
    ecp_byte_t pb_wdata;

    ecp_byte_t st_byte;
    ecp_byte_t st_s;
    logic [2:0] sys_in_s;
    logic cs_s;
    logic wp_s;
    logic tgl_s;
    logic ev;
    logic hw_guard;
    logic mem_ok;

    // status travels to the link as a quasi-static level; it moves rarely
    ecp_sync2 #(.W(8)) u_st_sync (
        .clk(sck),
        .d(st_byte),
        .q(st_s)
    );

    // pins and the frame toggle into the system clock
    ecp_sync2 #(.W(3)) u_sys_sync (
        .clk(clk),
        .d({cs_n, wp_n, b_q.tgl}),
        .q(sys_in_s)
    );

    assign cs_s = sys_in_s[2];
    assign wp_s = sys_in_s[1];
    assign tgl_s = sys_in_s[0];

    // link input side; hold freezes every field so no bit is lost or repeated
    always_comb begin
        ecp_byte_t rx;
        rx = {a_q.sh, si};
        a_d = a_q;
        b_d = b_q;
        pb_we = 1'b0;
        pb_idx = a_q.ptr;
        pb_wdata = rx;
        if (hold_n) begin // [R5]
            a_d.sh = rx[6:0]; // [R1] [R26]
            a_d.bitcnt = a_q.bitcnt + 3'h1;
            if (a_q.bitcnt == 3'h7) begin
                case (a_q.ph)
                    PH_OPCODE: begin
                        a_d.op = rx; // [R6]
                        b_d.tgl = ~b_q.tgl;
                        b_d.op = rx;
                        b_d.nbytes = 8'h00;
                        // unknown codes and anything but status read while busy drop out
                        b_d.ok = op_known(rx) && (!st_s[SR_BUSY] || rx == OP_STATUS_READ); // [R6] [R22]
                        if (!b_d.ok) begin
                            a_d.ph = PH_SKIP;
                        end else if (rx == OP_READ || rx == OP_WRITE) begin // [R7]
                            a_d.ph = PH_ADDR_HI;
                        end else if (rx == OP_STATUS_WRITE || rx == OP_STATUS_READ) begin // [R7] [R8]
                            a_d.ph = PH_DATA;
                        end else begin
                            a_d.ph = PH_SKIP; // [R8]
                        end
                    end
                    PH_ADDR_HI: begin
                        a_d.ahi = rx;
                        a_d.ph = PH_ADDR_LO;
                    end
                    PH_ADDR_LO: begin
                        a_d.raddr = {a_q.ahi, rx};
                        a_d.ptr = rx[6:0];
                        b_d.addr = {a_q.ahi, rx};
                        a_d.ph = PH_DATA;
                    end
                    PH_DATA: begin
                        if (a_q.op == OP_WRITE) begin
                            pb_we = 1'b1;
                            a_d.ptr = a_q.ptr + 7'h01; // [R23]
                        end
                        if (a_q.op == OP_STATUS_WRITE && b_q.nbytes == 8'h00) begin
                            b_d.srd = rx;
                        end
                        if ((a_q.op == OP_WRITE || a_q.op == OP_STATUS_WRITE) && b_q.nbytes != NBYTES_MAX) begin
                            b_d.nbytes = b_q.nbytes + 8'h01;
                        end
                        // the id page read pointer stays inside its 128 bytes
                        if (a_q.op == OP_READ && st_s[SR_PAGE_SELECT]) begin // [R15]
                            a_d.raddr = {a_q.raddr[15:7], a_q.raddr[6:0] + 7'h01};
                        end else if (a_q.op == OP_READ) begin
                            a_d.raddr = a_q.raddr + 16'h0001;
                        end
                    end
                    default: a_d.ph = PH_SKIP;
                endcase
            end
        end
    end

    // frame state dies with chip select high, a constant and nothing else
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            a_q <= '0;
        end else begin
            a_q <= a_d;
        end
    end

    // summary is reset only by the system reset so it outlives the frame
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    // page buffer written from the link, read by the engine while busy
    always_ff @(posedge sck) begin
        if (pb_we) begin
            pbuf[pb_idx] <= pb_wdata; // [R23] [R16]
        end
    end

    // link output side; each byte loads at its first falling edge
    always_comb begin
        ecp_byte_t src;
        logic tx_en;
        src = (a_q.op == OP_STATUS_READ) ? st_s : read_data;
        tx_en = (a_q.ph == PH_DATA) && (a_q.op == OP_READ || a_q.op == OP_STATUS_READ);
        c_d = c_q;
        if (hold_n) begin
            if (tx_en && a_q.bitcnt == 3'h0) begin
                c_d.sh = src;
                c_d.so = src[7]; // [R2] [R26]
                c_d.oe = 1'b1;
            end else if (tx_en) begin
                c_d.so = c_q.sh[3'h7 - a_q.bitcnt]; // [R2]
            end else begin
                c_d.oe = 1'b0;
            end
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            c_q <= '0; // [R3]
        end else begin
            c_q <= c_d;
        end
    end

    // hold and chip select float the output at once, not at the next edge
    assign so = c_q.so;
    assign so_oe = c_q.oe & hold_n & ~cs_n; // [R3]
    assign read_addr = a_q.raddr;
    assign read_id_page = st_s[SR_PAGE_SELECT]; // [R15]

    // status byte assembled from the system side fields
    always_comb begin
        st_byte = SR_RESET;
        st_byte[SR_BUSY] = s_q.busy; // [R9] [R10]
        st_byte[SR_WRITE_LATCH] = s_q.write_latch_bit;
        st_byte[SR_GUARD_HI:SR_GUARD_LO] = s_q.guard;
        st_byte[SR_PAGE_LOCK] = s_q.lock;
        st_byte[SR_ZERO] = 1'b0;
        st_byte[SR_PAGE_SELECT] = s_q.sel;
        st_byte[SR_PIN_GUARD] = s_q.pge;
    end

    // a frame is taken once chip select is high and its toggle has arrived
    assign ev = cs_s & (tgl_s != s_q.tgl_seen);
    assign hw_guard = ~wp_s & s_q.pge; // [R13]
    assign mem_ok = s_q.sel ? (!s_q.lock && s_q.guard != GUARD_FULL) : !addr_guarded(b_q.addr, s_q.guard);

    // system side decisions; summary fields are stable while chip select is high
    always_comb begin
        s_d = s_q;
        s_d.prog_start = 1'b0;
        s_d.pb_data = pbuf[prog_rd_idx];
        if (ev) begin
            s_d.tgl_seen = tgl_s;
        end
        if (s_q.busy) begin
            // the cycle runs on whether or not the host is selected
            if (s_q.timer == '0) begin // [R20] [R3]
                s_d.busy = 1'b0; // [R10]
                s_d.write_latch_bit = 1'b0; // [R25]
                if (s_q.cyc_mem) begin
                    s_d.sel = 1'b0; // [R17]
                end
            end else begin
                s_d.timer = s_q.timer - 1'b1;
            end
        end else if (ev && b_q.ok) begin
            case (b_q.op)
                OP_SET_LATCH: s_d.write_latch_bit = 1'b1; // [R11]
                OP_CLEAR_LATCH: s_d.write_latch_bit = 1'b0; // [R11]
                OP_STATUS_WRITE: begin
                    if (b_q.nbytes != 8'h00 && s_q.write_latch_bit && !hw_guard) begin // [R13] [R14]
                        s_d.guard = b_q.srd[SR_GUARD_HI:SR_GUARD_LO]; // [R24] [R12]
                        s_d.pge = b_q.srd[SR_PIN_GUARD]; // [R24]
                        if (!(b_q.srd[SR_PAGE_SELECT] && b_q.srd[SR_PAGE_LOCK])) begin // [R19]
                            s_d.sel = b_q.srd[SR_PAGE_SELECT]; // [R15]
                            s_d.lock = s_q.lock | b_q.srd[SR_PAGE_LOCK]; // [R18]
                        end
                        s_d.busy = 1'b1;
                        s_d.timer = TW'(WC_CYCLES_P - 1);
                        s_d.cyc_mem = 1'b0;
                    end
                end
                OP_WRITE: begin
                    if (b_q.nbytes != 8'h00 && s_q.write_latch_bit && mem_ok) begin // [R12] [R14] [R18]
                        s_d.prog_start = 1'b1;
                        s_d.prog_addr = b_q.addr;
                        s_d.prog_len = b_q.nbytes;
                        s_d.prog_id = s_q.sel; // [R15]
                        s_d.busy = 1'b1; // [R10]
                        s_d.timer = TW'(WC_CYCLES_P - 1);
                        s_d.cyc_mem = 1'b1;
                    end
                end
                OP_READ: s_d.sel = 1'b0; // [R17]
                default: s_d.sel = s_q.sel;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign status = st_byte;
    assign prog_start = s_q.prog_start;
    assign prog_addr = s_q.prog_addr;
    assign prog_len = s_q.prog_len;
    assign prog_id_page = s_q.prog_id;
    assign prog_rd_data = s_q.pb_data;

    // helper for the checks: length of the current busy stretch
    int busy_cnt;
    logic ev_sw;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= s_q.busy ? busy_cnt + 1 : 0;
        end
    end
    assign ev_sw = ev & b_q.ok & (b_q.op == OP_STATUS_WRITE) & (b_q.nbytes != 8'h00) & ~s_q.busy;

    chk_busy_length: assert property (@(posedge clk) disable iff (rst) // [R20]
        $fell(s_q.busy) |-> (busy_cnt == WC_CYCLES_P))
        else $error("write cycle length wrong");
    chk_latch_after_cycle: assert property (@(posedge clk) disable iff (rst) // [R25]
        $fell(s_q.busy) |-> !s_q.write_latch_bit)
        else $error("write latch still set after write cycle");
    chk_sw_no_latch: assert property (@(posedge clk) disable iff (rst) // [R14]
        ev_sw && !s_q.write_latch_bit |=> $stable(s_q.guard) && $stable(s_q.pge) && !s_q.busy)
        else $error("status write taken with latch clear");
    chk_sw_pin_guard: assert property (@(posedge clk) disable iff (rst) // [R13]
        ev_sw && !wp_s && s_q.pge |=> $stable(s_q.guard) && $stable(s_q.pge) && !s_q.busy)
        else $error("status write taken under pin guard");
    chk_select_lock_both: assert property (@(posedge clk) disable iff (rst) // [R19]
        ev_sw && b_q.srd[SR_PAGE_SELECT] && b_q.srd[SR_PAGE_LOCK] |=> $stable(s_q.sel) && $stable(s_q.lock))
        else $error("select and lock changed together");
    chk_lock_sticky: assert property (@(posedge clk) disable iff (rst) // [R18]
        s_q.lock |=> s_q.lock)
        else $error("page lock cleared");
    chk_prog_unguarded: assert property (@(posedge clk) disable iff (rst) // [R12]
        s_q.prog_start |-> (s_q.prog_id ? (!s_q.lock && s_q.guard != GUARD_FULL)
            : !addr_guarded(s_q.prog_addr, s_q.guard)) && s_q.busy)
        else $error("write started to a guarded address");
    chk_busy_ignores: assert property (@(posedge clk) disable iff (rst) // [R22]
        ev && s_q.busy && s_q.timer != '0 |=> $stable(s_q.write_latch_bit) && !s_q.prog_start)
        else $error("instruction obeyed during write cycle");
    chk_set_latch: assert property (@(posedge clk) disable iff (rst) // [R11]
        ev && b_q.ok && b_q.op == OP_SET_LATCH && !s_q.busy |=> s_q.write_latch_bit)
        else $error("set latch instruction lost");
    chk_output_float: assert property (@(posedge clk) disable iff (rst) // [R3]
        cs_n || !hold_n |-> !so_oe)
        else $error("output driven while deselected or held");

endmodule : ecp_cmd_protect

/* ecp_host_model.sv */
// host side of the serial link: frames transfers, msb first, mode 0 or mode 3
// assumes the bench calls frame() one call at a time
`timescale 1ns/1ps
module ecp_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    bit cpol = 1'b0; // set for mode 3, where sck idles high
    // sck stands still at its idle level outside frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // one frame of nb bytes; pause puts a hold after the first byte
    task automatic frame(input logic [31:0] tx, input int nb, input bit pause, output logic [31:0] rx);
        rx = '0;
        sck = cpol; // a mode change moves sck only while deselected
        #32 cs_n = 1'b0;
        if (cpol) begin
            #32 sck = 1'b0; // mode 3 opens on a falling edge
        end
        for (int i = nb * 8 - 1; i >= 0; i--) begin
            si = tx[i];
            #32 sck = 1'b1;
            rx = {rx[30:0], so_oe ? so : 1'bx};
            if (cpol && i == 0) begin
                break; // mode 3 leaves sck high at the end
            end
            #32 sck = 1'b0;
            if (pause && i == nb * 8 - 8) begin
                // hold moves while sck is low, never on its edge
                #8 hold_n = 1'b0;
                si = ~si;
                #100 hold_n = 1'b1;
            end
        end
        si = ~si; // released line shows no stale value
        #32 cs_n = 1'b1;
        #100;
    endtask : frame
endmodule : ecp_host_model

/* test_ecp_cmd_protect.sv */
// self-checking bench of the command front end with a host model
// assumes a memory that answers read_data combinationally
`timescale 1ns/1ps
module test_ecp_cmd_protect;
    import ecp_pkg::*;
    localparam int WC = 400; // short write cycle keeps the run brief
    logic clk, rst, wp_n, busy, prog_start, prog_id_page, read_id_page;
    logic sck, cs_n, si, so, so_oe, hold_n;
    ecp_addr_t read_addr, prog_addr, a;
    ecp_byte_t read_data, status, prog_len, prog_rd_data, d, op;
    ecp_pidx_t prog_rd_idx;
    logic [31:0] rx;
    int err_total = 0;
    int compares = 0;
    int starts = 0;
    int n0;
    ecp_cmd_protect #(.WC_CYCLES_P(WC)) dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .read_addr(read_addr),
        .read_id_page(read_id_page), .read_data(read_data), .busy(busy), .status(status),
        .prog_start(prog_start), .prog_addr(prog_addr), .prog_len(prog_len),
        .prog_id_page(prog_id_page), .prog_rd_idx(prog_rd_idx), .prog_rd_data(prog_rd_data));
    ecp_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
    // memory stand-in, the page select flips the top bit
    assign read_data = read_addr[7:0] ^ {read_id_page, 7'h2a};
    function automatic ecp_byte_t mem(input ecp_addr_t ad, input logic id);
        return ad[7:0] ^ {id, 7'h2a};
    endfunction : mem
    function automatic int guarded(input logic [1:0] g, input ecp_addr_t ad);
        return (g == 2'h3) || (g == 2'h2 && ad >= 16'h8000) || (g == 2'h1 && ad >= 16'hc000);
    endfunction : guarded
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count accepted writes, pulse lasts one clock
    always @(posedge clk) if (prog_start === 1'b1) starts <= starts + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic cmd(input ecp_byte_t c);
        host.frame({24'h0, c}, 1, 1'b0, rx);
    endtask : cmd
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < WC + 20) begin
            @(posedge clk) #1;
            n++;
        end
        chk(n <= WC, 1, "write cycle too long");
    endtask : wait_idle
    task automatic sr_write(input ecp_byte_t v);
        cmd(OP_SET_LATCH);
        host.frame({16'h0, OP_STATUS_WRITE, v}, 2, 1'b0, rx);
        wait_idle();
    endtask : sr_write
    task automatic mem_write(input ecp_addr_t ad, input ecp_byte_t dv);
        cmd(OP_SET_LATCH);
        host.frame({OP_WRITE, ad, dv}, 4, 1'b0, rx);
        wait_idle();
    endtask : mem_write
    // watchdog sized well beyond the expected run
    initial begin
        #500us;
        err_total++;
        report_and_stop();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        prog_rd_idx = '0;
        void'($urandom(32'h8010749a));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge clk); // settle before the first access; power-up wait shortened
        chk(status, SR_RESET, "reset status");
        cmd(OP_SET_LATCH);
        chk(status, 8'h02, "latch set");
        host.frame({16'h0, OP_STATUS_READ, 8'h0}, 2, 1'b1, rx);
        chk(rx[7:0], 8'h02, "status read");
        host.cpol = 1'b1;
        host.frame({16'h0, OP_STATUS_READ, 8'h0}, 2, 1'b0, rx);
        host.cpol = 1'b0;
        chk(rx[7:0], 8'h02, "status read mode 3");
        for (int i = 0; i < 4; i++) begin
            do op = 8'($urandom); while (op inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
            cmd(op);
            chk(status, 8'h02, "unknown opcode acted");
        end
        cmd(OP_CLEAR_LATCH);
        chk(status, 8'h00, "latch clear");
        $display("test opcodes done");
        host.frame({16'h0, OP_STATUS_WRITE, 8'h0c}, 2, 1'b0, rx);
        chk({busy, status}, 9'h000, "status write without latch");
        sr_write(8'h80 | (8'($urandom) & 8'h23));
        chk(status, 8'h80, "status write bits");
        @(posedge clk) #1 wp_n = 1'b0;
        sr_write(8'h8c);
        chk(status, 8'h82, "status write under pin guard");
        cmd(OP_CLEAR_LATCH);
        @(posedge clk) #1 wp_n = 1'b1;
        $display("test status write done");
        for (int g = 0; g < 4; g++) begin
            sr_write(8'h80 | 8'(g << 2));
            chk(status, 8'h80 | 8'(g << 2), "guard field");
            @(posedge clk) #1 wp_n = ~g[0];
            for (int k = 0; k < 4; k++) begin
                a = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : (k == 2) ? 16'hbfff : 16'hc000;
                d = 8'($urandom);
                n0 = starts;
                mem_write(a, d);
                chk(starts - n0, guarded(g[1:0], a) ? 0 : 1, "guard decision");
                if (!guarded(g[1:0], a)) begin
                    chk({prog_addr, prog_len}, {a, 8'h01}, "write start");
                    @(posedge clk) #1 prog_rd_idx = a[6:0];
                    repeat (3) @(posedge clk);
                    chk(prog_rd_data, d, "page buffer byte");
                end
            end
            @(posedge clk) #1 wp_n = 1'b1;
        end
        sr_write(8'h00);
        $display("test guard table done");
        cmd(OP_SET_LATCH);
        a = 16'($urandom) & 16'h7fff;
        host.frame({OP_WRITE, a, 8'h5c}, 4, 1'b0, rx);
        host.frame({16'h0, OP_STATUS_READ, 8'h0}, 2, 1'b0, rx);
        chk(rx[1:0], 2'b11, "busy seen in status read");
        cmd(OP_SET_LATCH);
        wait_idle();
        chk(status, 8'h00, "instruction obeyed while busy");
        $display("test busy done");
        sr_write(8'h40);
        chk(status, 8'h40, "page select");
        a = 16'($urandom);
        host.frame({OP_READ, a, 8'h0}, 4, 1'b0, rx);
        chk(rx[7:0], mem(a, 1'b1), "id page read");
        chk(status, 8'h00, "select after read");
        host.frame({OP_READ, a, 8'h0}, 4, 1'b0, rx);
        chk(rx[7:0], mem(a, 1'b0), "array read");
        sr_write(8'h40);
        n0 = starts;
        mem_write(16'hff85, 8'h33);
        chk({starts - n0, prog_id_page, status}, {32'd1, 1'b1, 8'h00}, "id page write");
        sr_write(8'h50);
        chk(status, 8'h00, "select and lock together");
        sr_write(8'h10);
        sr_write(8'h40);
        chk(status, 8'h50, "lock stays");
        n0 = starts;
        mem_write(16'h0005, 8'h11);
        chk(starts - n0, 0, "locked id page write");
        $display("test id page done");
        report_and_stop();
    end
endmodule : test_ecp_cmd_protect
